// [hw/dsd_defs.vh]
`ifndef DSD_DEFS_VH
`define DSD_DEFS_VH

// ----------------------------------------
// program space
// ----------------------------------------
`define DSD_PC_W            12
`define DSD_USER_LO         12'h0080
`define DSD_USER_HI         12'h0F9F
`define DSD_VEC_LO          12'h0FF0
`define DSD_VEC_HI          12'h0FF7
`define DSD_NMI_VEC         12'h0FFC
`define DSD_RST_VEC         12'h0FFE
`define DSD_FILL_BYTE       8'hFF
`define DSD_STACK_DEPTH     6

// ----------------------------------------
// data space
// ----------------------------------------
`define DSD_BANK_HI         8'h3F
`define DSD_WIN_LO          8'h40
`define DSD_WIN_HI          8'h7F
`define DSD_PTR_X           8'h80
`define DSD_PTR_Y           8'h81
`define DSD_SHORT_V         8'h82
`define DSD_SHORT_W         8'h83
`define DSD_RAM_LO          8'h84
`define DSD_RAM_HI          8'hBF
`define DSD_ROM_WINDOW_BASE 8'hC9
`define DSD_WIN_BITS        6

// region codes
`define DSD_RG_NONE         3'h0
`define DSD_RG_BANK         3'h1
`define DSD_RG_WIN          3'h2
`define DSD_RG_PTR          3'h3
`define DSD_RG_RAM          3'h4
`define DSD_RG_WBASE        3'h5
`define DSD_RG_PERIPH       3'h6

`endif

// [hw/dsd_ret_stack.v]
`timescale 1ns/1ps
// ----------------------------------------
// six-deep return address stack
// ----------------------------------------
module dsd_ret_stack #(
    parameter DEPTH = 6,
    parameter AW    = 12
) (
    // clock and reset
    input  wire          mclk_i,
    input  wire          rst_i,
    // push and pop
    input  wire          push_i,
    input  wire          pop_i,
    input  wire [AW-1:0] push_addr_i,
    // status
    output reg  [AW-1:0] top_o,
    output reg  [2:0]    level_o,
    output reg           overflow_o
);
    reg [AW-1:0] slot [0:DEPTH-1];
    integer i;

    // pushing when full drops the oldest entry, as a shift stack does
    always @(posedge mclk_i) begin
        if (push_i && !pop_i) begin
            slot[0] <= push_addr_i;                  // see RULE_02
            for (i = 1; i < DEPTH; i = i + 1) begin
                slot[i] <= slot[i-1];
            end
        end else if (pop_i && !push_i) begin
            for (i = 0; i < DEPTH - 1; i = i + 1) begin
                slot[i] <= slot[i+1];
            end
        end else if (push_i && pop_i) begin
            slot[0] <= push_addr_i;
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            level_o    <= 3'h0;
            overflow_o <= 1'b0;
            top_o      <= {AW{1'b0}};
        end else begin
            if (push_i && !pop_i) begin
                if (level_o == DEPTH[2:0]) begin
                    overflow_o <= 1'b1;
                end else begin
                    level_o <= level_o + 3'h1;
                end
                top_o <= push_addr_i;
            end else if (pop_i && !push_i) begin
                if (level_o != 3'h0) begin
                    level_o <= level_o - 3'h1;
                end
                top_o <= slot[1];
            end else if (push_i && pop_i) begin
                top_o <= push_addr_i;
            end
        end
    end
endmodule

// [hw/dsd_decoder.v]
`timescale 1ns/1ps
`include "dsd_defs.vh"
// How it works
// RULE_01 - instruction pointer is twelve bits wide
// RULE_02 - six-entry twelve-bit return stack
// RULE_03 - user code at 0080h to 0F9Fh
// RULE_04 - vectors at 0FF0h-0FF7h, 0FF8h-0FFBh reserved
// RULE_05 - NMI vector 0FFCh, reset vector 0FFEh
// RULE_06 - reserved program bytes filled with 0FFh
// RULE_07 - protection option blocks external readout
// RULE_08 - data 00h-3Fh is banked region
// RULE_09 - 080h-083h map to X, Y, V, W
// RULE_10 - sixty bytes RAM at 084h-0BFh
// RULE_11 - reads at 40h-7Fh come from program memory
// RULE_12 - window moves in 64-byte steps
// RULE_13 - window base high, data address low six
// RULE_14 - window base register is write only
// RULE_15 - reset leaves window base untouched
// RULE_16 - window base decoded at 0C9h, writes only
// RULE_17 - only base bits 5..0 are kept
// RULE_18 - window read shares fetch port, RAM timing
module dsd_decoder #(
    parameter PC_W  = 12,
    parameter DEPTH = 6
) (
    // clock and reset
    input  wire            mclk_i,
    input  wire            rst_i,
    // core instruction side
    input  wire [PC_W-1:0] fetch_addr_i,
    input  wire            fetch_req_i,
    input  wire            call_i,
    input  wire            ret_i,
    // core data side
    input  wire [7:0]      data_addr_i,
    input  wire            data_rd_i,
    input  wire            data_wr_i,
    input  wire [7:0]      data_wdata_i,
    // option and external readout
    input  wire            readout_protect_i,
    input  wire            ext_read_req_i,
    input  wire [PC_W-1:0] ext_read_addr_i,
    // program memory port
    output wire [PC_W-1:0] pmem_addr_o,
    output wire            pmem_rd_o,
    input  wire [7:0]      pmem_rdata_i,
    // decoded selects
    output wire [2:0]      data_region_o,
    output wire [1:0]      ptr_sel_o,
    output wire [5:0]      bank_offset_o,
    output wire [5:0]      ram_index_o,
    output wire            periph_sel_o,
    // program space class of fetch address
    output wire            fetch_user_o,
    output wire            fetch_vector_o,
    output wire            fetch_reserved_o,
    output wire            fetch_nmi_vec_o,
    output wire            fetch_rst_vec_o,
    // data and status outputs
    output reg  [7:0]      win_rdata_o,
    output reg             win_rvalid_o,
    output reg  [7:0]      ext_rdata_o,
    output reg             ext_rvalid_o,
    output wire [PC_W-1:0] ret_addr_o,
    output wire [2:0]      stack_level_o,
    output wire            stack_overflow_o
);
    // ----------------------------------------
    // window base register
    // ----------------------------------------
    // no reset branch: contents keep their value across reset by design
    reg  [`DSD_WIN_BITS-1:0] rom_window_base_reg;
    wire                     base_wr;

    assign base_wr = data_wr_i && (data_addr_i == `DSD_ROM_WINDOW_BASE); // see RULE_16

    always @(posedge mclk_i) begin
        if (base_wr) begin
            rom_window_base_reg <= data_wdata_i[`DSD_WIN_BITS-1:0]; // see RULE_17
        end                                                     // see RULE_15
    end

    // ----------------------------------------
    // data space decode
    // ----------------------------------------
    function [2:0] region_of;
        input [7:0] a;
        begin
            if (a <= `DSD_BANK_HI) begin
                region_of = `DSD_RG_BANK;                      // see RULE_08
            end else if (a <= `DSD_WIN_HI) begin
                region_of = `DSD_RG_WIN;                       // see RULE_11
            end else if (a <= `DSD_SHORT_W) begin
                region_of = `DSD_RG_PTR;                       // see RULE_09
            end else if (a <= `DSD_RAM_HI) begin
                region_of = `DSD_RG_RAM;                       // see RULE_10
            end else if (a == `DSD_ROM_WINDOW_BASE) begin
                region_of = `DSD_RG_WBASE;
            end else begin
                region_of = `DSD_RG_PERIPH;
            end
        end
    endfunction

    wire [2:0] region;
    wire       win_rd;

    assign region        = region_of(data_addr_i);
    assign data_region_o = region;
    assign ptr_sel_o     = data_addr_i[1:0];                   // see RULE_09
    assign bank_offset_o = data_addr_i[5:0];                   // see RULE_08
    assign ram_index_o   = data_addr_i[5:0] - 6'h04;           // see RULE_10
    assign periph_sel_o  = (region == `DSD_RG_PERIPH);
    // the base register never answers a read; the core sees no driver there
    assign win_rd        = data_rd_i && (region == `DSD_RG_WIN); // see RULE_14

    // ----------------------------------------
    // program space classes
    // ----------------------------------------
    function in_range;
        input [PC_W-1:0] a;
        input [PC_W-1:0] lo;
        input [PC_W-1:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    assign fetch_user_o     = in_range(fetch_addr_i, `DSD_USER_LO, `DSD_USER_HI); // see RULE_03
    assign fetch_vector_o   = in_range(fetch_addr_i, `DSD_VEC_LO, `DSD_VEC_HI);   // see RULE_04
    // each vector is a two-byte pair, so the odd byte is the vector's own as well
    assign fetch_nmi_vec_o  = in_range(fetch_addr_i, `DSD_NMI_VEC,
                                       `DSD_NMI_VEC | 12'h001);                   // see RULE_05
    assign fetch_rst_vec_o  = in_range(fetch_addr_i, `DSD_RST_VEC,
                                       `DSD_RST_VEC | 12'h001);                   // see RULE_05
    // image fill of 0FFh in these areas is left to the programmer
    assign fetch_reserved_o = !fetch_user_o && !fetch_vector_o
                              && !fetch_nmi_vec_o && !fetch_rst_vec_o;            // see RULE_06

    // ----------------------------------------
    // shared program memory port
    // ----------------------------------------
    // priority: window read, then fetch, then external readout; the window
    // read wins so that a data access keeps plain ram timing
    localparam [1:0] GNT_IDLE  = 2'h0;
    localparam [1:0] GNT_WIN   = 2'h1;
    localparam [1:0] GNT_FETCH = 2'h2;
    localparam [1:0] GNT_EXT   = 2'h3;

    wire            ext_req_ok;
    wire            ext_ok;
    wire [PC_W-1:0] win_addr;
    reg  [1:0]      grant;
    reg  [PC_W-1:0] port_addr;
    reg             port_rd;

    assign win_addr   = {rom_window_base_reg, data_addr_i[5:0]}; // see RULE_13
    // protection blocks external readout outright, no cycle is spent
    assign ext_req_ok = ext_read_req_i && !readout_protect_i;    // see RULE_07
    assign ext_ok     = (grant == GNT_EXT);

    always @* begin
        if (win_rd) begin
            grant = GNT_WIN;
        end else if (fetch_req_i) begin
            grant = GNT_FETCH;
        end else if (ext_req_ok) begin
            grant = GNT_EXT;
        end else begin
            grant = GNT_IDLE;
        end
    end

    // an idle port still shows the readout address, which costs nothing
    always @* begin
        case (grant)
            GNT_WIN: begin
                port_addr = win_addr;                            // see RULE_12
                port_rd   = 1'b1;
            end
            GNT_FETCH: begin
                port_addr = fetch_addr_i;                        // see RULE_01
                port_rd   = 1'b1;
            end
            GNT_EXT: begin
                port_addr = ext_read_addr_i;
                port_rd   = 1'b1;
            end
            default: begin
                port_addr = ext_read_addr_i;
                port_rd   = 1'b0;
            end
        endcase
    end

    assign pmem_addr_o = port_addr;
    assign pmem_rd_o   = port_rd;                                // see RULE_18

    always @(posedge mclk_i) begin
        if (rst_i) begin
            win_rdata_o  <= 8'h00;
            win_rvalid_o <= 1'b0;
            ext_rdata_o  <= 8'h00;
            ext_rvalid_o <= 1'b0;
        end else begin
            win_rvalid_o <= win_rd;                              // see RULE_18
            ext_rvalid_o <= ext_ok;
            if (win_rd) begin
                win_rdata_o <= pmem_rdata_i;
            end
            if (ext_ok) begin
                ext_rdata_o <= pmem_rdata_i;
            end
        end
    end

    // ----------------------------------------
    // return stack
    // ----------------------------------------
    dsd_ret_stack #(
        .DEPTH (DEPTH),
        .AW    (PC_W)
    ) u_stack (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .push_i      (call_i),
        .pop_i       (ret_i),
        .push_addr_i (fetch_addr_i),
        .top_o       (ret_addr_o),
        .level_o     (stack_level_o),
        .overflow_o  (stack_overflow_o)
    );                                                           // see RULE_02
endmodule

// [tb/dsd_pmem_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// program memory image, combinational read
// ----------------------------------------
module dsd_pmem_model (
    // address side
    input  wire logic [11:0] addr_i,
    input  wire logic        rd_i,
    // data side
    output logic      [7:0]  rdata_o
);
    logic       rsv;
    logic [7:0] pat;
    // reserved bytes hold the erased fill value
    assign rsv = addr_i < 12'h0080 || (addr_i >= 12'h0FA0 && addr_i <= 12'h0FEF)
                 || (addr_i >= 12'h0FF8 && addr_i <= 12'h0FFB);
    assign pat = rsv ? 8'hFF : addr_i[7:0] ^ {addr_i[3:0], addr_i[11:8]};
    // idle bus shows the inverse so a stale byte never passes
    assign rdata_o = rd_i ? pat : ~pat;
endmodule

// [tb/dsd_decoder_checker.sv]
`timescale 1ns/1ps
// ----------------------------------------
// decoder port checker
// ----------------------------------------
module dsd_decoder_checker #(parameter PC_W = 12) (
    input wire logic            mclk_i,
    input wire logic            rst_i,
    input wire logic [PC_W-1:0] fetch_addr_i,
    input wire logic            call_i,
    input wire logic            ret_i,
    input wire logic [7:0]      data_addr_i,
    input wire logic            data_rd_i,
    input wire logic            readout_protect_i,
    input wire logic [PC_W-1:0] pmem_addr_o,
    input wire logic            pmem_rd_o,
    input wire logic [7:0]      pmem_rdata_i,
    input wire logic [2:0]      data_region_o,
    input wire logic [1:0]      ptr_sel_o,
    input wire logic [5:0]      bank_offset_o,
    input wire logic [5:0]      ram_index_o,
    input wire logic            fetch_vector_o,
    input wire logic [7:0]      win_rdata_o,
    input wire logic            win_rvalid_o,
    input wire logic            ext_rvalid_o,
    input wire logic [PC_W-1:0] ret_addr_o
);
    logic win;
    assign win = data_rd_i && data_addr_i >= 8'h40 && data_addr_i <= 8'h7F;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_win_addr; win |-> pmem_rd_o && pmem_addr_o[5:0] == data_addr_i[5:0]; endproperty
    a_win_addr: assert property (p_win_addr) else $error("window address low bits");
    property p_win_vld; win |=> win_rvalid_o; endproperty
    a_win_vld: assert property (p_win_vld) else $error("window read late");
    property p_win_dat; win |=> win_rdata_o == $past(pmem_rdata_i); endproperty
    a_win_dat: assert property (p_win_dat) else $error("window data wrong");
    property p_base_rd; data_rd_i && data_addr_i == 8'hC9 |=> !win_rvalid_o; endproperty
    a_base_rd: assert property (p_base_rd) else $error("base register readable");
    property p_ram; data_addr_i inside {[8'h84:8'hBF]} |->
        data_region_o == 3'h4 && ram_index_o == 6'(data_addr_i - 8'h84); endproperty
    a_ram: assert property (p_ram) else $error("ram decode");
    property p_bank; data_addr_i <= 8'h3F |->
        data_region_o == 3'h1 && bank_offset_o == data_addr_i[5:0]; endproperty
    a_bank: assert property (p_bank) else $error("bank decode");
    property p_ptr; data_addr_i inside {[8'h80:8'h83]} |->
        data_region_o == 3'h3 && ptr_sel_o == data_addr_i[1:0]; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer decode");
    property p_prot; readout_protect_i |=> !ext_rvalid_o; endproperty
    a_prot: assert property (p_prot) else $error("protected readout answered");
    property p_push; call_i && !ret_i |=> ret_addr_o == $past(fetch_addr_i); endproperty
    a_push: assert property (p_push) else $error("push lost");
    property p_vec; fetch_addr_i inside {[12'h0FF0:12'h0FF7]} |-> fetch_vector_o; endproperty
    a_vec: assert property (p_vec) else $error("vector class");
endmodule

// [tb/tb_data_space_decoder_rom_window.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_data_space_decoder_rom_window;
    logic        mclk_i = 0, rst_i = 1, fetch_req_i = 0, call_i = 0, ret_i = 0;
    logic        data_rd_i = 0, data_wr_i = 0, readout_protect_i = 1, ext_read_req_i = 0;
    logic [11:0] fetch_addr_i = 0, ext_read_addr_i = 0, pmem_addr_o, ret_addr_o;
    logic [7:0]  data_addr_i = 0, data_wdata_i = 0, pmem_rdata_i, win_rdata_o, ext_rdata_o;
    logic [5:0]  bank_offset_o, ram_index_o;
    logic [2:0]  data_region_o, stack_level_o;
    logic [1:0]  ptr_sel_o;
    logic        pmem_rd_o, periph_sel_o, fetch_user_o, fetch_vector_o, fetch_reserved_o;
    logic        fetch_nmi_vec_o, fetch_rst_vec_o, win_rvalid_o, ext_rvalid_o, stack_overflow_o;
    logic [4:0]  fcls;
    int          errors = 0, checks = 0;
    logic [7:0]  ra [10] = '{8'h00, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'h83, 8'h84, 8'hBF, 8'hC9, 8'hC0};
    logic [2:0]  rg [10] = '{1, 1, 2, 2, 3, 3, 4, 4, 5, 6};
    logic [11:0] fa [9] = '{12'h080, 12'hF9F, 12'h07F, 12'hFA0, 12'hFF0, 12'hFF7,
                            12'hFF8, 12'hFFC, 12'hFFE};
    logic [4:0]  fc [9] = '{5'h10, 5'h10, 5'h04, 5'h04, 5'h08, 5'h08, 5'h04, 5'h02, 5'h01};
    assign fcls = {fetch_user_o, fetch_vector_o, fetch_reserved_o, fetch_nmi_vec_o,
                   fetch_rst_vec_o};
    always #20 mclk_i = ~mclk_i;
    dsd_decoder uut (
        .mclk_i            (mclk_i),
        .rst_i             (rst_i),
        .fetch_addr_i      (fetch_addr_i),
        .fetch_req_i       (fetch_req_i),
        .call_i            (call_i),
        .ret_i             (ret_i),
        .data_addr_i       (data_addr_i),
        .data_rd_i         (data_rd_i),
        .data_wr_i         (data_wr_i),
        .data_wdata_i      (data_wdata_i),
        .readout_protect_i (readout_protect_i),
        .ext_read_req_i    (ext_read_req_i),
        .ext_read_addr_i   (ext_read_addr_i),
        .pmem_addr_o       (pmem_addr_o),
        .pmem_rd_o         (pmem_rd_o),
        .pmem_rdata_i      (pmem_rdata_i),
        .data_region_o     (data_region_o),
        .ptr_sel_o         (ptr_sel_o),
        .bank_offset_o     (bank_offset_o),
        .ram_index_o       (ram_index_o),
        .periph_sel_o      (periph_sel_o),
        .fetch_user_o      (fetch_user_o),
        .fetch_vector_o    (fetch_vector_o),
        .fetch_reserved_o  (fetch_reserved_o),
        .fetch_nmi_vec_o   (fetch_nmi_vec_o),
        .fetch_rst_vec_o   (fetch_rst_vec_o),
        .win_rdata_o       (win_rdata_o),
        .win_rvalid_o      (win_rvalid_o),
        .ext_rdata_o       (ext_rdata_o),
        .ext_rvalid_o      (ext_rvalid_o),
        .ret_addr_o        (ret_addr_o),
        .stack_level_o     (stack_level_o),
        .stack_overflow_o  (stack_overflow_o)
    );
    dsd_pmem_model pmem (.addr_i(pmem_addr_o), .rd_i(pmem_rd_o), .rdata_o(pmem_rdata_i));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task step;
        @(posedge mclk_i);
        #1;
    endtask
    task wr_base(input [7:0] d);
        data_addr_i = 8'hC9;
        data_wr_i = 1;
        data_wdata_i = d;
        step;
        data_wr_i = 0;
    endtask
    task rd_win(input [7:0] a, input [11:0] pa, input [7:0] d);
        data_addr_i = a;
        data_rd_i = 1;
        #1 `CHK(pmem_addr_o, pa)
        step;
        data_rd_i = 0;
        `CHK(win_rvalid_o, 1'b1)
        `CHK(win_rdata_o, d)
    endtask
    task print_verdict;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        #200000;
        errors++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        #1 rst_i = 0;
        step;
        wr_base(8'h28);
        rd_win(8'h59, 12'hA19, 8'h83);
        wr_base(8'hFF);
        rd_win(8'h7F, 12'hFFF, 8'h00);
        wr_base(8'hC0);
        rd_win(8'h40, 12'h000, 8'hFF);
        data_addr_i = 8'hC9;
        data_rd_i = 1;
        step;
        data_rd_i = 0;
        `CHK(win_rvalid_o, 1'b0)
        for (int i = 0; i < 10; i++) begin
            data_addr_i = ra[i];
            step;
            `CHK(data_region_o, rg[i])
            `CHK(periph_sel_o, rg[i] == 3'h6)
        end
        fetch_req_i = 1;
        for (int i = 0; i < 9; i++) begin
            fetch_addr_i = fa[i];
            step;
            `CHK(fcls, fc[i])
            `CHK(pmem_addr_o, fa[i])
        end
        call_i = 1;
        for (int i = 1; i <= 7; i++) begin
            fetch_addr_i = 12'h100 + 12'(i);
            step;
            `CHK(ret_addr_o, fetch_addr_i)
            `CHK(stack_level_o, 3'(i > 6 ? 6 : i))
            `CHK(stack_overflow_o, i > 6)
        end
        call_i = 0;
        ret_i = 1;
        step;
        ret_i = 0;
        `CHK(ret_addr_o, 12'h106)
        `CHK(stack_level_o, 3'h5)
        fetch_req_i = 0;
        ext_read_addr_i = 12'hA19;
        ext_read_req_i = 1;
        step;
        `CHK(ext_rvalid_o, 1'b0)
        readout_protect_i = 0;
        step;
        ext_read_req_i = 0;
        `CHK(ext_rvalid_o, 1'b1)
        `CHK(ext_rdata_o, 8'h83)
        // a reset in mid-run clears the stack but must keep the window base
        wr_base(8'h15);
        rst_i = 1;
        step;
        rst_i = 0;
        `CHK(stack_level_o, 3'h0)
        `CHK(stack_overflow_o, 1'b0)
        `CHK(ret_addr_o, 12'h000)
        rd_win(8'h7F, 12'h57F, 8'h8A);
        print_verdict;
    end
endmodule
bind dsd_decoder dsd_decoder_checker #(.PC_W(PC_W)) chk (
    .mclk_i            (mclk_i),
    .rst_i             (rst_i),
    .fetch_addr_i      (fetch_addr_i),
    .call_i            (call_i),
    .ret_i             (ret_i),
    .data_addr_i       (data_addr_i),
    .data_rd_i         (data_rd_i),
    .readout_protect_i (readout_protect_i),
    .pmem_addr_o       (pmem_addr_o),
    .pmem_rd_o         (pmem_rd_o),
    .pmem_rdata_i      (pmem_rdata_i),
    .data_region_o     (data_region_o),
    .ptr_sel_o         (ptr_sel_o),
    .bank_offset_o     (bank_offset_o),
    .ram_index_o       (ram_index_o),
    .fetch_vector_o    (fetch_vector_o),
    .win_rdata_o       (win_rdata_o),
    .win_rvalid_o      (win_rvalid_o),
    .ext_rvalid_o      (ext_rvalid_o),
    .ret_addr_o        (ret_addr_o)
);
